/* dv/radio_core_model.sv */
// radio core stand-in: readiness levels that settle some cycles after a mode change
// assumes the mode input comes from the bench on i_clk_sys
`default_nettype none

module radio_core_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // control
  input wire logic [2:0] i_mode,
  input wire logic [3:0] i_lat,
  // readiness
  output logic o_xo_running,
  output logic o_pll_locked,
  output logic o_level_sampling,
  output logic o_pa_ramp_done,
  output logic o_rx_chain_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] mode_r;
  logic [5:0] cnt_r;
  logic up;
  logic tx;
  logic rx;
  always_ff @(posedge i_clk_sys)
  begin
    mode_r <= i_mode;
    if (i_rst || i_mode != mode_r)
      cnt_r <= 6'h00;
    else if (cnt_r != 6'h3f)
      cnt_r <= cnt_r + 6'h01;
  end
  // the mode compare stops a stale count from showing ready in a new mode
  assign up = cnt_r >= {2'h0, i_lat} && i_mode == mode_r;
  assign tx = i_mode == radio_irq_pkg::MODE_TX;
  assign rx = i_mode == radio_irq_pkg::MODE_RX;
  assign o_xo_running = up && i_mode != radio_irq_pkg::MODE_SLEEP;
  assign o_pll_locked = up && (tx || rx || i_mode == radio_irq_pkg::MODE_FS);
  assign o_level_sampling = up && rx;
  assign o_pa_ramp_done = up && tx;
  assign o_rx_chain_done = rx && i_mode == mode_r && cnt_r >= {1'b0, i_lat, 1'b0};
endmodule

`default_nettype wire

/* dv/radio_irq_flags_tb_top.sv */
// self-checking bench of the flag, pin routing and clock output block
// assumes the core model drives readiness; bench drives bus and event inputs
`default_nettype none

module radio_irq_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] addr = 9'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'hf;
  logic [2:0] mode = 3'h0;
  logic [3:0] lat = 4'h8;
  logic lvl_v = 1'b0;
  logic [7:0] lvl = 8'h00;
  logic tick = 1'b0;
  logic fifo_e = 1'b0;
  logic imode = 1'b0;
  logic sync = 1'b0;
  logic amatch = 1'b0;
  logic afilt = 1'b1;
  logic pkt = 1'b1;
  logic rc = 1'b0;
  logic pay = 1'b0;
  logic [31:0] rdata;
  logic wreq;
  logic xo, pll, samp, ramp, chain, clko, irq;
  logic [5:0] pin;
  logic [7:0] lf = 8'h24;
  logic [31:0] q;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  logic p;

  radio_core_model core (.i_clk_sys(clk), .i_rst(rst), .i_mode(mode), .i_lat(lat), .o_xo_running(xo),
    .o_pll_locked(pll), .o_level_sampling(samp), .o_pa_ramp_done(ramp), .o_rx_chain_done(chain));
  radio_irq_flags dut (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_mode(mode), .i_xo_running(xo), .i_pll_locked(pll),
    .i_level_sampling(samp), .i_pa_ramp_done(ramp), .i_rx_chain_done(chain), .i_level_valid(lvl_v),
    .i_measured_signal_level(lvl), .i_bit_tick(tick), .i_payload_ready(pay), .i_fifo_emptied(fifo_e),
    .i_intermediate_mode(imode), .i_sync_detect(sync), .i_address_match(amatch),
    .i_address_filter_en(afilt), .i_packet_mode(pkt), .i_rc_osc(rc), .o_pin(pin), .o_clk_out(clko),
    .o_irq(irq));

  initial forever #4 clk = ~clk;
  // rc stand-in deliberately unrelated to the system clock
  initial forever #37 rc = ~rc;

  // ==========================================================
  // reporting
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      $display("BAD %0t run too long", $time);
      wrap_up();
    end
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic pexp(input logic [1:0] s, input logic pm, input logic [7:0] f);
    logic [3:0] t;
    t = pm ? {f[7], f[2], f[3], f[0]} : {f[4], f[3], f[5], f[6]};
    return t[s];
  endfunction

  task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    do
    begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrt(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(q, {24'h0, e});
  endtask

  task automatic go(input logic [2:0] m, input int w);
    @(posedge clk);
    mode <= m;
    repeat (w) @(posedge clk);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdc(radio_irq_pkg::IDX_ROUTE_A, 8'h00);
    rdc(radio_irq_pkg::IDX_ROUTE_B, 8'h07);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h80);
    rdc(radio_irq_pkg::IDX_LEVEL_LIMIT, 8'he4);
    rdc(radio_irq_pkg::IDX_START_WAIT, 8'h00);
    rdc(radio_irq_pkg::IDX_AFTER_WAIT, 8'h00);
    rdc(radio_irq_pkg::IDX_IRQ_MASK, 8'h00);
    rdc(radio_irq_pkg::IDX_IRQ_STATUS, 8'h00);
    wrt(7'h30, 8'h5a);
    rdc(7'h30, 8'h00);
    be <= 4'he;
    wrt(radio_irq_pkg::IDX_ROUTE_A, 8'hff);
    be <= 4'hf;
    rdc(radio_irq_pkg::IDX_ROUTE_A, 8'h00);
    repeat (4)
    begin
      lf = lfsr(lf);
      wrt(radio_irq_pkg::IDX_ROUTE_A, lf);
      rdc(radio_irq_pkg::IDX_ROUTE_A, lf);
      wrt(radio_irq_pkg::IDX_ROUTE_B, lf);
      rdc(radio_irq_pkg::IDX_ROUTE_B, lf & 8'hf7);
    end
    // every clock output code, edges counted over 64 cycles
    for (int c = 0; c < 8; c++)
    begin
      wrt(radio_irq_pkg::IDX_ROUTE_B, c[7:0]);
      repeat (4) @(posedge clk);
      n = 0;
      p = clko;
      repeat (64)
      begin
        @(posedge clk);
        if (clko !== p)
          n++;
        p = clko;
      end
      if (c == 6)
        chk(n != 0, 1);
      else
        chk(n, c < 6 ? 64 >> c : 0);
    end
    // pin0 shows mode ready in packet mode
    wrt(radio_irq_pkg::IDX_ROUTE_A, 8'hc0);
    go(radio_irq_pkg::MODE_STANDBY, 20);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h80);
    go(radio_irq_pkg::MODE_FS, 2);
    chk(pin[0], 0);
    repeat (12) @(posedge clk);
    chk(pin[0], 1);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h90);
    go(radio_irq_pkg::MODE_TX, 20);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hb0);
    go(radio_irq_pkg::MODE_RX, 30);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd0);
    wrt(radio_irq_pkg::IDX_IRQ_STATUS, 8'hff);
    wrt(radio_irq_pkg::IDX_IRQ_MASK, 8'h08);
    chk(irq, 0);
    lvl <= 8'he4;
    lvl_v <= 1'b1;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd0);
    lf = lfsr(lf);
    lvl <= lf | 8'he5;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd8);
    chk(irq, 1);
    repeat (4)
    begin
      lf = lfsr(lf);
      pkt <= lf[0];
      wrt(radio_irq_pkg::IDX_ROUTE_A, lf);
      wrt(radio_irq_pkg::IDX_ROUTE_B, lf);
      repeat (2) @(posedge clk);
      for (int i = 0; i < 6; i++)
        chk(pin[i], pexp(lf[7 - 2 * (i % 4) -: 2], lf[0], 8'hd8));
    end
    lvl_v <= 1'b0;
    wrt(radio_irq_pkg::IDX_FLAGS, 8'h08);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd0);
    chk(irq, 1);
    wrt(radio_irq_pkg::IDX_IRQ_STATUS, 8'h08);
    @(posedge clk);
    chk(irq, 0);
    // sync flag: address filter, then clear rights per mode
    pkt <= 1'b1;
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd0);
    amatch <= 1'b1;
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd1);
    wrt(radio_irq_pkg::IDX_FLAGS, 8'h01);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd1);
    pkt <= 1'b0;
    wrt(radio_irq_pkg::IDX_FLAGS, 8'h01);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd0);
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    @(posedge clk) fifo_e <= 1'b1;
    @(posedge clk) fifo_e <= 1'b0;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'hd0);
    lvl_v <= 1'b1;
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    go(radio_irq_pkg::MODE_STANDBY, 20);
    lvl_v <= 1'b0;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h80);
    imode <= 1'b1;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h82);
    imode <= 1'b0;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h80);
    // prompt core, receive-start wait of one unit
    lat <= 4'h1;
    wrt(radio_irq_pkg::IDX_START_WAIT, 8'h01);
    go(radio_irq_pkg::MODE_RX, 2);
    tick <= 1'b1;
    repeat (14) @(posedge clk);
    tick <= 1'b0;
    bus(1'b0, radio_irq_pkg::IDX_FLAGS, 8'h00);
    chk(q[2], 0);
    tick <= 1'b1;
    repeat (3) @(posedge clk);
    tick <= 1'b0;
    bus(1'b0, radio_irq_pkg::IDX_FLAGS, 8'h00);
    chk(q[2], 1);
    @(posedge clk) fifo_e <= 1'b1;
    @(posedge clk) fifo_e <= 1'b0;
    bus(1'b0, radio_irq_pkg::IDX_FLAGS, 8'h00);
    chk(q[2], 0);
    // after-level wait of one unit: payload stops it (j=0), otherwise it expires (j=1)
    wrt(radio_irq_pkg::IDX_AFTER_WAIT, 8'h01);
    for (int j = 0; j < 2; j++)
    begin
      lvl_v <= 1'b1;
      tick <= 1'b1;
      @(posedge clk) lvl_v <= 1'b0;
      repeat (8) @(posedge clk);
      pay <= !j;
      @(posedge clk) pay <= 1'b0;
      repeat (9) @(posedge clk);
      tick <= 1'b0;
      bus(1'b0, radio_irq_pkg::IDX_FLAGS, 8'h00);
      chk(q[2], j);
    end
    // in sleep the auto flag trails the intermediate-mode input
    go(radio_irq_pkg::MODE_SLEEP, 20);
    imode <= 1'b1;
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h80);
    rdc(radio_irq_pkg::IDX_FLAGS, 8'h82);
    wrap_up();
  end
endmodule

`default_nettype wire

/* logic/pin_router.sv */
// six general output pins, each picking one of four flags by a 2-bit selector
// assumes flag inputs are next-state values on the same clock, so pins match the register
`default_nettype none

module pin_router #(
  parameter int NUM_PINS = 6
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // selection
  input wire logic [2*NUM_PINS-1:0] i_sel,
  input wire logic i_packet_mode,
  input wire logic [3:0] i_cont_src,
  input wire logic [3:0] i_pkt_src,
  // pins
  output logic [NUM_PINS-1:0] o_pin
);

  typedef struct packed {
    logic [NUM_PINS-1:0] pin;
  } state_s;

  state_s s_r;
  state_s s_nxt;
  logic [NUM_PINS-1:0] pick;

  // ==========================================================
  // per-pin selection
  genvar k;
  generate
    for (k = 0; k < NUM_PINS; k++)
    begin : g_pin
      assign pick[k] = i_packet_mode ? i_pkt_src[i_sel[2*k +: 2]] : i_cont_src[i_sel[2*k +: 2]];
    end
  endgenerate

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pin = pick;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign o_pin = s_r.pin;

endmodule

`default_nettype wire

/* logic/radio_irq_flags.sv */
// status flags, interrupt, pin routing and clock output of the packet radio
// assumes core status inputs are on i_clk_sys; only the rc oscillator input is foreign
`default_nettype none

module radio_irq_flags (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [8:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // radio core status
  input wire logic [2:0] i_mode,
  input wire logic i_xo_running,
  input wire logic i_pll_locked,
  input wire logic i_level_sampling,
  input wire logic i_pa_ramp_done,
  input wire logic i_rx_chain_done,
  input wire logic i_level_valid,
  input wire logic [7:0] i_measured_signal_level,
  input wire logic i_bit_tick,
  input wire logic i_payload_ready,
  input wire logic i_fifo_emptied,
  input wire logic i_intermediate_mode,
  input wire logic i_sync_detect,
  input wire logic i_address_match,
  input wire logic i_address_filter_en,
  input wire logic i_packet_mode,
  // rc oscillator, foreign domain
  input wire logic i_rc_osc,
  // pins and interrupt
  output logic [5:0] o_pin,
  output logic o_clk_out,
  output logic o_irq
);

  localparam int LAG = radio_irq_pkg::AUTO_SLEEP_LAG_CYCLES;

  typedef struct packed {
    logic [7:0] route_a;
    logic [7:0] route_b;
    logic [7:0] level_limit;
    logic [7:0] start_wait;
    logic [7:0] after_wait;
    logic [7:0] flags;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [2:0] prev_mode;
    logic [LAG-1:0] auto_dly;
    logic [1:0][11:0] tmr_cnt;
    logic [1:0] tmr_run;
    logic [radio_irq_pkg::DIV_WIDTH-1:0] divcnt;
    logic clk_out;
    logic rc_s1;
    logic rc_s2;
    logic irq;
    logic wreq;
    logic [7:0] rdata;
  } state_s;

  state_s s;
  state_s s_nxt;

  logic req;
  logic accept;
  logic wr;
  logic [6:0] idx;
  logic [7:0] wd;
  logic rx;
  logic tx;
  logic fs;
  logic rx_enter;
  logic leave_rx;
  logic mode_chg;
  logic ready_cond;
  logic lock_cond;
  logic level_evt;
  logic sync_evt;
  logic tmo_evt;
  logic [7:0] w1c_flags;
  logic [3:0] cont_src;
  logic [3:0] pkt_src;

  // ==========================================================
  // bus decode
  assign req = i_avs_read | i_avs_write;
  assign accept = req & ~s.wreq;
  assign wr = i_avs_write & accept & i_avs_byteenable[0];
  assign idx = i_avs_address[8:2];
  assign wd = i_avs_writedata[7:0];

  // ==========================================================
  // mode decode
  assign rx = (i_mode == radio_irq_pkg::MODE_RX);
  assign tx = (i_mode == radio_irq_pkg::MODE_TX);
  assign fs = (i_mode == radio_irq_pkg::MODE_FS);
  assign mode_chg = (i_mode != s.prev_mode);
  assign rx_enter = rx & (s.prev_mode != radio_irq_pkg::MODE_RX);
  assign leave_rx = ~rx;
  assign lock_cond = (fs | rx | tx) & i_pll_locked;
  assign level_evt = rx & i_level_valid & (i_measured_signal_level > s.level_limit);
  // address term only counts when filtering is on
  assign sync_evt = rx & i_sync_detect & (~i_address_filter_en | i_address_match);
  assign w1c_flags = (wr && idx == radio_irq_pkg::IDX_FLAGS) ? wd : 8'h00;

  always_comb
  begin
    case (i_mode)
      radio_irq_pkg::MODE_SLEEP: ready_cond = 1'b1;
      radio_irq_pkg::MODE_STANDBY: ready_cond = i_xo_running;
      radio_irq_pkg::MODE_FS: ready_cond = i_pll_locked;
      radio_irq_pkg::MODE_RX: ready_cond = i_level_sampling;
      radio_irq_pkg::MODE_TX: ready_cond = i_pa_ramp_done;
      default: ready_cond = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    logic [1:0] t_start;
    logic [1:0] t_stop;
    logic [1:0] t_exp;
    logic [1:0][11:0] t_lim;
    logic [2:0] code;
    t_start = '0;
    t_stop = '0;
    t_exp = '0;
    t_lim = '0;
    code = '0;
    s_nxt = s;
    s_nxt.prev_mode = i_mode;

    // bus: one wait cycle, read data latched before the accepting edge
    s_nxt.wreq = ~(req & s.wreq);
    if (req & s.wreq)
    begin
      case (idx)
        radio_irq_pkg::IDX_ROUTE_A: s_nxt.rdata = s.route_a;
        radio_irq_pkg::IDX_ROUTE_B: s_nxt.rdata = {s.route_b[7:4], 1'b0, s.route_b[2:0]};
        radio_irq_pkg::IDX_FLAGS: s_nxt.rdata = s.flags;
        radio_irq_pkg::IDX_LEVEL_LIMIT: s_nxt.rdata = s.level_limit;
        radio_irq_pkg::IDX_START_WAIT: s_nxt.rdata = s.start_wait;
        radio_irq_pkg::IDX_AFTER_WAIT: s_nxt.rdata = s.after_wait;
        radio_irq_pkg::IDX_IRQ_STATUS: s_nxt.rdata = s.irq_status;
        radio_irq_pkg::IDX_IRQ_MASK: s_nxt.rdata = s.irq_mask;
        default: s_nxt.rdata = 8'h00;
      endcase
    end
    if (wr)
    begin
      case (idx)
        radio_irq_pkg::IDX_ROUTE_A: s_nxt.route_a = wd;
        radio_irq_pkg::IDX_ROUTE_B: s_nxt.route_b = {wd[7:4], 1'b0, wd[2:0]};
        radio_irq_pkg::IDX_LEVEL_LIMIT: s_nxt.level_limit = wd;
        radio_irq_pkg::IDX_START_WAIT: s_nxt.start_wait = wd;
        radio_irq_pkg::IDX_AFTER_WAIT: s_nxt.after_wait = wd;
        radio_irq_pkg::IDX_IRQ_MASK: s_nxt.irq_mask = wd;
        default: s_nxt.rdata = s_nxt.rdata;
      endcase
    end

    // timers: 0 counts from rx entry to level event, 1 from level event to payload
    // last counted tick is count*16-1, so expiry lands on tick count*16; zero counts never start
    t_lim[0] = {s.start_wait - 8'h01, radio_irq_pkg::BITS_PER_WAIT_UNIT};
    t_lim[1] = {s.after_wait - 8'h01, radio_irq_pkg::BITS_PER_WAIT_UNIT};
    t_start[0] = rx_enter & (s.start_wait != 8'h00);
    t_start[1] = level_evt & (s.after_wait != 8'h00);
    t_stop[0] = level_evt | leave_rx;
    t_stop[1] = i_payload_ready | leave_rx;
    for (int t = 0; t < 2; t++)
    begin
      if (t_start[t])
      begin
        s_nxt.tmr_run[t] = 1'b1;
        s_nxt.tmr_cnt[t] = 12'h000;
      end
      else if (t_stop[t])
        s_nxt.tmr_run[t] = 1'b0;
      else if (s.tmr_run[t] && i_bit_tick)
      begin
        s_nxt.tmr_cnt[t] = s.tmr_cnt[t] + 12'h001;
        if (s.tmr_cnt[t] == t_lim[t])
        begin
          t_exp[t] = 1'b1;
          s_nxt.tmr_run[t] = 1'b0;
        end
      end
    end
    tmo_evt = |t_exp;

    // flags; hardware sets win over every clear except a mode change, which clears mode ready even when ready_cond is set
    s_nxt.flags[radio_irq_pkg::BIT_MODE_OK] = ~mode_chg & (s.flags[radio_irq_pkg::BIT_MODE_OK] | ready_cond);
    s_nxt.flags[radio_irq_pkg::BIT_RECEIVE_OK] =
      rx & (s.flags[radio_irq_pkg::BIT_RECEIVE_OK] | i_rx_chain_done);
    s_nxt.flags[radio_irq_pkg::BIT_TRANSMIT_OK] =
      tx & (s.flags[radio_irq_pkg::BIT_TRANSMIT_OK] | i_pa_ramp_done);
    s_nxt.flags[radio_irq_pkg::BIT_SYNTH_LOCKED] = lock_cond;
    s_nxt.flags[radio_irq_pkg::BIT_LEVEL] = level_evt |
      (rx & s.flags[radio_irq_pkg::BIT_LEVEL] & ~w1c_flags[radio_irq_pkg::BIT_LEVEL]);
    s_nxt.flags[radio_irq_pkg::BIT_TIMEOUT] = tmo_evt |
      (rx & s.flags[radio_irq_pkg::BIT_TIMEOUT] & ~i_fifo_emptied);
    // sleep path lags so the flag can trail the real transition there
    s_nxt.auto_dly = {s.auto_dly[LAG-2:0], i_intermediate_mode};
    s_nxt.flags[radio_irq_pkg::BIT_AUTO_SEQUENCE] =
      (i_mode == radio_irq_pkg::MODE_SLEEP) ? s.auto_dly[LAG-1] : i_intermediate_mode;
    s_nxt.flags[radio_irq_pkg::BIT_SYNC_MATCH] = sync_evt |
      (rx & s.flags[radio_irq_pkg::BIT_SYNC_MATCH] & ~i_fifo_emptied
       & ~(w1c_flags[radio_irq_pkg::BIT_SYNC_MATCH] & ~i_packet_mode));

    // sticky interrupt status on each rising flag, write one to clear
    s_nxt.irq_status = (s_nxt.flags & ~s.flags) |
      (s.irq_status & ~((wr && idx == radio_irq_pkg::IDX_IRQ_STATUS) ? wd : 8'h00));
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);

    // clock output; crystal clock is taken as half of i_clk_sys
    s_nxt.rc_s1 = i_rc_osc;
    s_nxt.rc_s2 = s.rc_s1;
    s_nxt.divcnt = s.divcnt + {{(radio_irq_pkg::DIV_WIDTH-1){1'b0}}, 1'b1};
    code = s.route_b[radio_irq_pkg::CLOCK_OUTPUT_SELECT_MSB:0];
    if (code == radio_irq_pkg::CLOCK_OUTPUT_SELECT_OFF)
      s_nxt.clk_out = 1'b0;
    else if (code == radio_irq_pkg::CLOCK_OUTPUT_SELECT_RC)
      s_nxt.clk_out = s.rc_s2;
    else
      s_nxt.clk_out = s_nxt.divcnt[code];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      s <= '0;
      s.route_a <= radio_irq_pkg::ROUTE_A_RST;
      s.route_b <= radio_irq_pkg::ROUTE_B_RST;
      s.level_limit <= radio_irq_pkg::LEVEL_LIMIT_RST;
      s.start_wait <= radio_irq_pkg::WAIT_RST;
      s.after_wait <= radio_irq_pkg::WAIT_RST;
      s.flags <= radio_irq_pkg::FLAGS_RST;
      s.irq_mask <= radio_irq_pkg::IRQ_MASK_RST;
      s.prev_mode <= radio_irq_pkg::MODE_SLEEP;
      s.wreq <= 1'b1;
    end
    else
      s <= s_nxt;
  end

  // ==========================================================
  // pin routing from next flags, so pin and register agree
  assign pkt_src = {s_nxt.flags[radio_irq_pkg::BIT_MODE_OK], s_nxt.flags[radio_irq_pkg::BIT_TIMEOUT],
    s_nxt.flags[radio_irq_pkg::BIT_LEVEL], s_nxt.flags[radio_irq_pkg::BIT_SYNC_MATCH]};
  assign cont_src = {s_nxt.flags[radio_irq_pkg::BIT_SYNTH_LOCKED], s_nxt.flags[radio_irq_pkg::BIT_LEVEL],
    s_nxt.flags[radio_irq_pkg::BIT_TRANSMIT_OK], s_nxt.flags[radio_irq_pkg::BIT_RECEIVE_OK]};

  pin_router #(
    .NUM_PINS(6)
  ) u_pin_router (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_sel({s.route_b[5:4], s.route_b[7:6], s.route_a[1:0], s.route_a[3:2], s.route_a[5:4], s.route_a[7:6]}),
    .i_packet_mode(i_packet_mode),
    .i_cont_src(cont_src),
    .i_pkt_src(pkt_src),
    .o_pin(o_pin)
  );

  assign o_avs_readdata = {24'h000000, s.rdata};
  assign o_avs_waitrequest = s.wreq;
  assign o_clk_out = s.clk_out;
  assign o_irq = s.irq;

  // ==========================================================
  // assertions
  property p_clk_off;
    @(posedge i_clk_sys) disable iff (i_rst)
    s.route_b[2:0] == radio_irq_pkg::CLOCK_OUTPUT_SELECT_OFF |=> !o_clk_out;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock output not off");

  property p_clk_div2;
    @(posedge i_clk_sys) disable iff (i_rst)
    $past(s.route_b[2:0]) == 3'h1 |-> o_clk_out == s.divcnt[1];
  endproperty
  a_clk_div2: assert property (p_clk_div2) else $error("clock output divide wrong");

  property p_sel_reset;
    @(posedge i_clk_sys)
    $past(i_rst) && !i_rst |-> s.route_a == 8'h00 && s.route_b[7:4] == 4'h0 && s.route_b[2:0] == 3'h7;
  endproperty
  a_sel_reset: assert property (p_sel_reset) else $error("selector reset wrong");

  property p_mode_clear;
    @(posedge i_clk_sys) disable iff (i_rst)
    mode_chg |=> !s.flags[7];
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode flag kept on change");

  property p_rx_ok;
    @(posedge i_clk_sys) disable iff (i_rst)
    !rx |=> !s.flags[6];
  endproperty
  a_rx_ok: assert property (p_rx_ok) else $error("receive flag outside rx");

  property p_tx_ok;
    @(posedge i_clk_sys) disable iff (i_rst)
    tx && i_pa_ramp_done ##1 tx |=> s.flags[5];
  endproperty
  a_tx_ok: assert property (p_tx_ok) else $error("transmit flag lost");

  property p_lock;
    @(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |-> s.flags[4] == $past(lock_cond);
  endproperty
  a_lock: assert property (p_lock) else $error("lock flag wrong");

  property p_level;
    @(posedge i_clk_sys) disable iff (i_rst)
    level_evt |=> s.flags[3];
  endproperty
  a_level: assert property (p_level) else $error("level event lost");

  property p_timeout;
    @(posedge i_clk_sys) disable iff (i_rst)
    tmo_evt |=> s.flags[2] && s.irq_status[2];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_start_off;
    @(posedge i_clk_sys) disable iff (i_rst)
    rx_enter && s.start_wait == 8'h00 && !s.tmr_run[0] |=> !s.tmr_run[0];
  endproperty
  a_start_off: assert property (p_start_off) else $error("zero count started timer");

  property p_auto;
    @(posedge i_clk_sys) disable iff (i_rst)
    i_mode != radio_irq_pkg::MODE_SLEEP |=> s.flags[1] == $past(i_intermediate_mode);
  endproperty
  a_auto: assert property (p_auto) else $error("auto flag wrong");

  property p_sync;
    @(posedge i_clk_sys) disable iff (i_rst)
    sync_evt |=> s.flags[0];
  endproperty
  a_sync: assert property (p_sync) else $error("sync event lost");

  property p_sync_ro;
    @(posedge i_clk_sys) disable iff (i_rst)
    s.flags[0] && w1c_flags[0] && i_packet_mode && rx && !i_fifo_emptied |=> s.flags[0];
  endproperty
  a_sync_ro: assert property (p_sync_ro) else $error("sync cleared in packet mode");

  property p_pin0;
    @(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) && $past(s.route_a[7:6]) == 2'h0 && $past(i_packet_mode) |-> o_pin[0] == s.flags[0];
  endproperty
  a_pin0: assert property (p_pin0) else $error("pin differs from flag");

  c_timeout: cover property (@(posedge i_clk_sys) disable iff (i_rst) tmo_evt);
  c_irq: cover property (@(posedge i_clk_sys) disable iff (i_rst) $rose(o_irq));
  c_write: cover property (@(posedge i_clk_sys) disable iff (i_rst) wr ##1 i_avs_read);

endmodule

`default_nettype wire

/* logic/radio_irq_pkg.sv */
// package of register indices, reset values and field positions
// assumes a byte-addressed Avalon-MM slave with one 32-bit word per register
`default_nettype none

package radio_irq_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [6:0] IDX_ROUTE_A = 7'h25;
  localparam logic [6:0] IDX_ROUTE_B = 7'h26;
  localparam logic [6:0] IDX_FLAGS = 7'h27;
  localparam logic [6:0] IDX_LEVEL_LIMIT = 7'h29;
  localparam logic [6:0] IDX_START_WAIT = 7'h2a;
  localparam logic [6:0] IDX_AFTER_WAIT = 7'h2b;
  localparam logic [6:0] IDX_IRQ_STATUS = 7'h40;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h41;

  // ==========================================================
  // values after reset
  localparam logic [7:0] ROUTE_A_RST = 8'h00;
  localparam logic [7:0] ROUTE_B_RST = 8'h07;
  localparam logic [7:0] FLAGS_RST = 8'h80;
  localparam logic [7:0] LEVEL_LIMIT_RST = 8'he4;
  localparam logic [7:0] WAIT_RST = 8'h00;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;

  // ==========================================================
  // flag bit positions in event_flags_first
  localparam int BIT_MODE_OK = 7;
  localparam int BIT_RECEIVE_OK = 6;
  localparam int BIT_TRANSMIT_OK = 5;
  localparam int BIT_SYNTH_LOCKED = 4;
  localparam int BIT_LEVEL = 3;
  localparam int BIT_TIMEOUT = 2;
  localparam int BIT_AUTO_SEQUENCE = 1;
  localparam int BIT_SYNC_MATCH = 0;

  // ==========================================================
  // clock output selector codes and field
  localparam logic [2:0] CLOCK_OUTPUT_SELECT_DIV32 = 3'h5;
  localparam logic [2:0] CLOCK_OUTPUT_SELECT_RC = 3'h6;
  localparam logic [2:0] CLOCK_OUTPUT_SELECT_OFF = 3'h7;
  localparam int CLOCK_OUTPUT_SELECT_MSB = 2;

  // ==========================================================
  // operating mode codes on the mode input
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_FS = 3'h2;
  localparam logic [2:0] MODE_TX = 3'h3;
  localparam logic [2:0] MODE_RX = 3'h4;

  // ==========================================================
  // counts
  localparam logic [3:0] BITS_PER_WAIT_UNIT = 4'hf;
  localparam int AUTO_SLEEP_LAG_CYCLES = 2;
  localparam int DIV_WIDTH = 6;

endpackage

`default_nettype wire
